// *** sbs_pkg.sv ***
// Constants and types shared by the burst static memory core.
// Assumes one clock domain; nothing here is synthesised on its own.
package sbs_pkg;

   // ---------------------------------------------------------
   // Array geometry
   // ---------------------------------------------------------
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned UPPER_W = 14;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned LANES = 4;
   localparam int unsigned LANE_W = 8;
   localparam int unsigned WORDS = 65536;

   // ---------------------------------------------------------
   // Reset values and pin encodings
   // ---------------------------------------------------------
   localparam logic STROBE_IDLE = 1'b1;
   localparam logic [3:0] LANES_NONE = 4'h0;
   localparam logic [3:0] LANES_ALL = 4'hF;
   localparam logic [2:0] CHIP_SEL_IDLE = 3'h3;
   localparam logic MODE_RESET = 1'b1;
   localparam logic FLOW_RESET = 1'b1;

   // ---------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam int unsigned CTRL_SLEEP_BIT = 0;
   localparam int unsigned ST_ACTIVE_BIT = 0;
   localparam int unsigned ST_MODE_BIT = 1;
   localparam int unsigned ST_FLOW_BIT = 2;
   localparam int unsigned ST_WRITE_BIT = 3;
   localparam int unsigned ST_LOW_LSB = 4;
   localparam logic CTRL_SLEEP_RESET = 1'b0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum {SBS_OP_IDLE, SBS_OP_READ, SBS_OP_WRITE} sbs_op_t;

endpackage : sbs_pkg

// *** sbs_mem_if.sv ***
// Array access port between the core's control and its storage.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface sbs_mem_if;
   logic en;
   logic we;
   logic [sbs_pkg::LANES-1:0] be;
   logic [sbs_pkg::ADDR_W-1:0] addr;
   logic [sbs_pkg::DATA_W-1:0] wdata;
   logic [sbs_pkg::DATA_W-1:0] rdata;
   modport ctrl (output en, output we, output be, output addr, output wdata, input rdata);
   modport mem (input en, input we, input be, input addr, input wdata, output rdata);
endinterface : sbs_mem_if
`default_nettype wire

// *** sbs_burst_ctr.sv ***
// Two-bit burst counter giving the low word address bits.
// Assumes load and step come from registered controls.
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_ctr (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic step_i,
   input wire logic interleave_i,
   input wire logic [1:0] load_low_i,
   output logic [1:0] low_o
);
   logic [1:0] idx;
   logic [1:0] base;
   logic [1:0] next_idx;
   logic [1:0] next_base;

   always_comb
   begin
      next_base = load_i ? load_low_i : base;
      next_idx = load_i ? 2'h0 : (step_i ? 2'(idx + 2'h1) : idx);
      if (interleave_i)
         low_o = next_base ^ next_idx;
      else
         low_o = 2'(next_base + next_idx);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         idx <= 2'h0;
         base <= 2'h0;
      end
      else
      begin
         idx <= next_idx;
         base <= next_base;
      end
   end

   linear_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (step_i && !load_i && !interleave_i && $past(!interleave_i))
      |-> low_o == 2'($past(low_o) + 2'h1))
      else $error("linear burst did not count up by one");

   inter_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (load_i && interleave_i) ##1 (step_i && !load_i && interleave_i)
      |-> low_o == ($past(low_o) ^ 2'h1))
      else $error("interleaved burst second word wrong");

endmodule : sbs_burst_ctr
`default_nettype wire

// *** sbs_mem_array.sv ***
// Storage of the core, one array per byte lane, registered read.
// Assumes requests arrive one per clock on the memory modport.
`timescale 1ns/1ps
`default_nettype none
module sbs_mem_array (
   input wire logic clk_i,
   sbs_mem_if.mem bus
);
   genvar g;
   generate
      for (g = 0; g < sbs_pkg::LANES; g++)
      begin : lane
         logic [sbs_pkg::LANE_W-1:0] cells [0:sbs_pkg::WORDS-1];
         logic [sbs_pkg::LANE_W-1:0] rd;

         // Each strobe owns one lane; the write needs no later strobe
         always_ff @(posedge clk_i)
         begin
            if (bus.en && bus.we && bus.be[g])
               cells[bus.addr] <= bus.wdata[g*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
         end

         // This register is the output data register
         always_ff @(posedge clk_i)
         begin
            if (bus.en && !bus.we)
               rd <= cells[bus.addr];
         end

         assign bus.rdata[g*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] = rd;
      end
   endgenerate

endmodule : sbs_mem_array
`default_nettype wire

// *** sbs_sram_core.sv ***
// Pipelined burst static memory core, 64K words of 32 bits.
// Assumes the requester runs on REF_CLK_I; AHB-Lite reaches two
// small registers. Two-way data lines are split into in, out, enable.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_core (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic [sbs_pkg::UPPER_W-1:0] UPPER_WORD_ADDRESS_I,
   input wire logic [1:0] LOW_WORD_ADDRESS_I,
   input wire logic PROC_ADDR_STROBE_N_I,
   input wire logic CTRL_ADDR_STROBE_N_I,
   input wire logic BURST_ADVANCE_N_I,
   input wire logic GLOBAL_WRITE_N_I,
   input wire logic BYTE_WRITE_GATE_N_I,
   input wire logic [sbs_pkg::LANES-1:0] BYTE_STROBE_N_I,
   input wire logic [2:0] CHIP_SELECTS_I,
   input wire logic OUTPUT_ENABLE_N_I,
   input wire logic SLEEP_REQUEST_I,
   input wire logic BURST_ORDER_SELECT_I,
   input wire logic FLOW_THROUGH_SELECT_I,
   input wire logic [sbs_pkg::DATA_W-1:0] DATA_LINES_I,
   output logic [sbs_pkg::DATA_W-1:0] DATA_LINES_O,
   output logic DATA_LINES_OE_O,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   output logic [31:0] HRDATA_O
);

   // ---------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ---------------------------------------------------------
   // Static strap pins
   // ---------------------------------------------------------
   // Bit 1 order select, bit 0 flow-through; both are board straps,
   // so a change is accepted only once two stages agree.
   logic [1:0] strap_s1;
   logic [1:0] strap_s2;
   logic [1:0] strap_s3;
   logic [1:0] strap;

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_s1 <= {sbs_pkg::MODE_RESET, sbs_pkg::FLOW_RESET};
         strap_s2 <= {sbs_pkg::MODE_RESET, sbs_pkg::FLOW_RESET};
         strap_s3 <= {sbs_pkg::MODE_RESET, sbs_pkg::FLOW_RESET};
         strap <= {sbs_pkg::MODE_RESET, sbs_pkg::FLOW_RESET};
      end
      else
      begin
         strap_s1 <= {BURST_ORDER_SELECT_I, FLOW_THROUGH_SELECT_I};
         strap_s2 <= strap_s1;
         strap_s3 <= strap_s2;
         strap <= ((strap_s2 ~^ strap_s3) & strap_s2) | ((strap_s2 ^ strap_s3) & strap);
      end
   end

   // ---------------------------------------------------------
   // Input registers
   // ---------------------------------------------------------
   logic [sbs_pkg::ADDR_W-1:0] addr_q;
   logic pas_q;
   logic cas_q;
   logic adv_q;
   logic gw_q;
   logic bwe_q;
   logic [sbs_pkg::LANES-1:0] bs_q;
   logic [2:0] cs_q;
   logic sleep_q;
   logic [sbs_pkg::DATA_W-1:0] wdata_q;

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_q <= '0;
         pas_q <= sbs_pkg::STROBE_IDLE;
         cas_q <= sbs_pkg::STROBE_IDLE;
         adv_q <= sbs_pkg::STROBE_IDLE;
         gw_q <= sbs_pkg::STROBE_IDLE;
         bwe_q <= sbs_pkg::STROBE_IDLE;
         bs_q <= sbs_pkg::LANES_ALL;
         cs_q <= sbs_pkg::CHIP_SEL_IDLE;
         sleep_q <= 1'b0;
         wdata_q <= '0;
      end
      else
      begin
         addr_q <= {UPPER_WORD_ADDRESS_I, LOW_WORD_ADDRESS_I};
         pas_q <= PROC_ADDR_STROBE_N_I;
         cas_q <= CTRL_ADDR_STROBE_N_I;
         adv_q <= BURST_ADVANCE_N_I;
         gw_q <= GLOBAL_WRITE_N_I;
         bwe_q <= BYTE_WRITE_GATE_N_I;
         bs_q <= BYTE_STROBE_N_I;
         cs_q <= CHIP_SELECTS_I;
         sleep_q <= SLEEP_REQUEST_I;
         wdata_q <= DATA_LINES_I;
      end
   end

   // ---------------------------------------------------------
   // Cycle decode
   // ---------------------------------------------------------
   logic ctrl_sleep;
   logic selected;
   logic wr_any;
   logic [sbs_pkg::LANES-1:0] lanes;
   logic load;
   logic step;
   logic deselect;
   logic active;
   sbs_pkg::sbs_op_t op;

   assign selected = !cs_q[0] && !cs_q[1] && cs_q[2];
   assign wr_any = !gw_q || (!bwe_q && bs_q != sbs_pkg::LANES_ALL);

   always_comb
   begin
      if (!gw_q)
         lanes = sbs_pkg::LANES_ALL;
      else if (!bwe_q)
         lanes = ~bs_q;
      else
         lanes = sbs_pkg::LANES_NONE;
   end

   // Processor strobe is gated by the main select, so with that
   // select high the controller strobe decides the cycle.
   always_comb
   begin
      op = sbs_pkg::SBS_OP_IDLE;
      load = 1'b0;
      step = 1'b0;
      deselect = 1'b0;
      if (sleep_q || ctrl_sleep)
         deselect = 1'b1;
      else if (!pas_q && !cs_q[0])
      begin
         load = selected;
         deselect = !selected;
         op = selected ? sbs_pkg::SBS_OP_READ : sbs_pkg::SBS_OP_IDLE;
      end
      else if (!cas_q)
      begin
         load = selected;
         deselect = !selected;
         if (selected)
            op = wr_any ? sbs_pkg::SBS_OP_WRITE : sbs_pkg::SBS_OP_READ;
      end
      else if (active)
      begin
         step = !adv_q;
         op = wr_any ? sbs_pkg::SBS_OP_WRITE : sbs_pkg::SBS_OP_READ;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         active <= 1'b0;
      else if (load)
         active <= 1'b1;
      else if (deselect)
         active <= 1'b0;
   end

   // ---------------------------------------------------------
   // Burst address
   // ---------------------------------------------------------
   logic [sbs_pkg::UPPER_W-1:0] upper_q;
   logic [1:0] low;

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         upper_q <= '0;
      else if (load)
         upper_q <= addr_q[sbs_pkg::ADDR_W-1:2];
   end

   sbs_burst_ctr u_ctr (
      .clk_i(REF_CLK_I),
      .rst_n_i(rst_n),
      .load_i(load),
      .step_i(step),
      .interleave_i(strap[1]),
      .load_low_i(addr_q[1:0]),
      .low_o(low)
   );

   // ---------------------------------------------------------
   // Array access and data lines
   // ---------------------------------------------------------
   sbs_mem_if mem_if ();
   logic rd_valid;
   logic last_write;

   assign mem_if.en = (op != sbs_pkg::SBS_OP_IDLE);
   assign mem_if.we = (op == sbs_pkg::SBS_OP_WRITE);
   assign mem_if.be = lanes;
   assign mem_if.addr = {load ? addr_q[sbs_pkg::ADDR_W-1:2] : upper_q, low};
   assign mem_if.wdata = wdata_q;

   sbs_mem_array u_array (
      .clk_i(REF_CLK_I),
      .bus(mem_if.mem)
   );

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_valid <= 1'b0;
         last_write <= 1'b0;
      end
      else
      begin
         rd_valid <= (op == sbs_pkg::SBS_OP_READ);
         if (op != sbs_pkg::SBS_OP_IDLE)
            last_write <= (op == sbs_pkg::SBS_OP_WRITE);
      end
   end

   // Enable and sleep act without the clock; the requester must hold
   // enable high around its own write data, since the lines are shared.
   assign DATA_LINES_OE_O = rst_n && rd_valid && !OUTPUT_ENABLE_N_I
                            && !SLEEP_REQUEST_I && !ctrl_sleep;
   assign DATA_LINES_O = mem_if.rdata;

   // ---------------------------------------------------------
   // Register bus slave
   // ---------------------------------------------------------
   logic ph_valid;
   logic ph_write;
   logic [7:0] ph_addr;
   logic [31:0] status;
   logic [31:0] rdata_q;
   logic take;

   assign take = HSEL_I && HREADY_I && HTRANS_I[1] && HSIZE_I == sbs_pkg::HSIZE_WORD;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = sbs_pkg::HRESP_OKAY;
   assign HRDATA_O = rdata_q;

   always_comb
   begin
      status = '0;
      status[sbs_pkg::ST_ACTIVE_BIT] = active;
      status[sbs_pkg::ST_MODE_BIT] = strap[1];
      status[sbs_pkg::ST_FLOW_BIT] = strap[0];
      status[sbs_pkg::ST_WRITE_BIT] = last_write;
      status[sbs_pkg::ST_LOW_LSB +: 2] = low;
   end

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= '0;
      end
      else if (HREADY_I)
      begin
         ph_valid <= take;
         ph_write <= HWRITE_I;
         ph_addr <= HADDR_I[7:0];
      end
   end

   // Read data is fetched at the address phase so it stands as a flop
   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= '0;
      else if (take && !HWRITE_I)
      begin
         if (HADDR_I[7:0] == sbs_pkg::CTRL_OFS)
            rdata_q <= {31'h0, ctrl_sleep};
         else if (HADDR_I[7:0] == sbs_pkg::STATUS_OFS)
            rdata_q <= status;
         else
            rdata_q <= '0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_sleep <= sbs_pkg::CTRL_SLEEP_RESET;
      else if (ph_valid && ph_write && ph_addr == sbs_pkg::CTRL_OFS)
         ctrl_sleep <= HWDATA_I[sbs_pkg::CTRL_SLEEP_BIT];
   end

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   oe_gate_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
      DATA_LINES_OE_O |-> (!OUTPUT_ENABLE_N_I && !SLEEP_REQUEST_I
                           && $past(op == sbs_pkg::SBS_OP_READ)))
      else $error("data lines driven outside a read");

   powerup_hiz_a: assert property (@(posedge REF_CLK_I)
      !rst_n |-> !DATA_LINES_OE_O)
      else $error("data lines driven during reset");

   input_capture_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
      ##1 addr_q == $past({UPPER_WORD_ADDRESS_I, LOW_WORD_ADDRESS_I}))
      else $error("address not captured at the edge");

   read_pipe_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
      (mem_if.en && !mem_if.we) |=> rd_valid ##1 !rd_valid || $past(mem_if.en && !mem_if.we))
      else $error("read data not presented one cycle later");

   global_write_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
      (PROC_ADDR_STROBE_N_I && !CTRL_ADDR_STROBE_N_I && CHIP_SELECTS_I == 3'h4
       && !GLOBAL_WRITE_N_I && !SLEEP_REQUEST_I && !ctrl_sleep)
      |=> (mem_if.we && mem_if.be == sbs_pkg::LANES_ALL))
      else $error("global write did not write all bytes");

   gate_read_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
      (GLOBAL_WRITE_N_I && (BYTE_WRITE_GATE_N_I || BYTE_STROBE_N_I == 4'hF))
      |=> !mem_if.we)
      else $error("write without an enabled byte");

   proc_read_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
      (!PROC_ADDR_STROBE_N_I && !CHIP_SELECTS_I[0]) |=> !mem_if.we)
      else $error("processor strobe began a write");

   upper_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
      (active && !load && mem_if.en && $past(mem_if.en))
      |-> mem_if.addr[15:2] == $past(mem_if.addr[15:2]))
      else $error("upper address moved inside a burst");

   suspend_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
      (active && !load && adv_q && $past(mem_if.en) && !deselect)
      |-> mem_if.addr == $past(mem_if.addr))
      else $error("suspended burst changed address");

endmodule : sbs_sram_core
`default_nettype wire

// *** sbs_requester.sv ***
// Requester model: a cache controller driving the burst memory pins.
// Assumes the core samples every pin except output enable on the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module sbs_requester (
   input wire logic clk_i,
   input wire logic hold_oe_i,
   output logic ps_n_o,
   output logic cc_n_o,
   output logic adv_n_o,
   output logic gw_n_o,
   output logic bwe_n_o,
   output logic [3:0] bs_n_o,
   output logic [2:0] cs_o,
   output logic [15:0] addr_o,
   output logic [31:0] data_o,
   output logic oe_n_o
);
   logic wr;

   // Enable held off over a whole write cycle, so the lines never fight
   assign oe_n_o = hold_oe_i | wr;

   initial
   begin
      ps_n_o = 1'h1;
      cc_n_o = 1'h0;
      adv_n_o = 1'h1;
      gw_n_o = 1'h1;
      bwe_n_o = 1'h1;
      bs_n_o = 4'hF;
      cs_o = 3'h1;
      addr_o = 16'h0000;
      data_o = 32'h00000000;
      wr = 1'h0;
   end

   // -----------------------------------------------------------
   // One pin cycle; c = {proc, ctrl, select, advance, global, gate}
   // -----------------------------------------------------------
   task drive(input logic [5:0] c, input logic [3:0] bs, input logic [15:0] a,
      input logic [31:0] d);
      logic w;
      w = c[5] & (~c[1] | (~c[0] & (bs != 4'hF)));
      @(posedge clk_i);
      ps_n_o <= c[5];
      cc_n_o <= c[4];
      cs_o <= c[3] ? 3'h4 : 3'h1;
      adv_n_o <= c[2];
      gw_n_o <= c[1];
      bwe_n_o <= c[0];
      bs_n_o <= bs;
      addr_o <= a;
      wr <= w;
      // Released lines toggle, so a stale word can never pass for data
      data_o <= w ? d : ~data_o;
   endtask : drive
endmodule : sbs_requester
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the burst static memory core.
// Assumes the requester model drives the pins and the bench is bus master.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {logic [5:0] ctl; logic [3:0] bs; logic [15:0] a;
      logic [31:0] d; logic chk; logic [31:0] x;} sbs_row_t;
   localparam sbs_row_t ROWS [24] = '{
      '{6'h2D, 4'hF, 16'h0010, 32'hA0A1A2A3, 1'h0, 32'h0},
      '{6'h2E, 4'h0, 16'h0011, 32'hB0B1B2B3, 1'h0, 32'h0},
      '{6'h2D, 4'hF, 16'h0012, 32'hC0C1C2C3, 1'h0, 32'h0},
      '{6'h2D, 4'h5, 16'h0013, 32'hD0D1D2D3, 1'h0, 32'h0},
      '{6'h2E, 4'hA, 16'h0010, 32'hEEEEEEEE, 1'h0, 32'h0},
      '{6'h2F, 4'h0, 16'h0011, 32'h0, 1'h1, 32'hB0B1B2B3},
      '{6'h2E, 4'hF, 16'h0012, 32'h0, 1'h1, 32'hC0C1C2C3},
      '{6'h0D, 4'h0, 16'h0011, 32'h0, 1'h1, 32'hB0B1B2B3},
      '{6'h3B, 4'hF, 16'hFFFF, 32'h0, 1'h1, 32'hA0EEA2EE},
      '{6'h3F, 4'hF, 16'hFFFF, 32'h0, 1'h1, 32'hA0EEA2EE},
      '{6'h3B, 4'hF, 16'hFFFF, 32'h0, 1'h1, 32'hD0D1D2D3},
      '{6'h3B, 4'hF, 16'hFFFF, 32'h0, 1'h1, 32'hC0C1C2C3},
      '{6'h27, 4'hF, 16'h0000, 32'h0, 1'h0, 32'h0},
      '{6'h3B, 4'hF, 16'h0000, 32'h0, 1'h0, 32'h0},
      '{6'h2D, 4'hF, 16'h0021, 32'h01020304, 1'h0, 32'h0},
      '{6'h39, 4'hF, 16'hFFFF, 32'h05060708, 1'h0, 32'h0},
      '{6'h2F, 4'hF, 16'h0020, 32'h0, 1'h1, 32'h05060708},
      '{6'h3B, 4'hF, 16'hFFFF, 32'h0, 1'h1, 32'h01020304},
      '{6'h27, 4'hF, 16'h0000, 32'h0, 1'h0, 32'h0},
      '{6'h0D, 4'h0, 16'h0011, 32'h0, 1'h1, 32'hB0B1B2B3},
      '{6'h3B, 4'hF, 16'hFFFF, 32'h0, 1'h1, 32'hC0C1C2C3},
      '{6'h3B, 4'hF, 16'hFFFF, 32'h0, 1'h1, 32'hD0D1D2D3},
      '{6'h3B, 4'hF, 16'hFFFF, 32'h0, 1'h1, 32'hA0EEA2EE},
      '{6'h27, 4'hF, 16'h0000, 32'h0, 1'h0, 32'h0}};
   logic clk, rst_n, sleep, order, flow, hold_oe, mute;
   logic ps_n, cc_n, adv_n, gw_n, bwe_n, oe_n, dq_oe;
   logic [3:0] bs_n;
   logic [2:0] cs;
   logic [15:0] addr;
   logic [31:0] req_data, dq_out, rd, hrdata, haddr, hwdata;
   logic hsel, hwrite, hready, hresp, exp_v, st1, st2;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] exp_x, d1, d2;
   int err_total, n_tests;

   initial
   begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   sbs_requester i_sbs_requester (.clk_i(clk), .hold_oe_i(hold_oe), .ps_n_o(ps_n),
      .cc_n_o(cc_n), .adv_n_o(adv_n), .gw_n_o(gw_n), .bwe_n_o(bwe_n), .bs_n_o(bs_n),
      .cs_o(cs), .addr_o(addr), .data_o(req_data), .oe_n_o(oe_n));

   sbs_sram_core i_sbs_sram_core (.REF_CLK_I(clk), .RST_N_I(rst_n),
      .UPPER_WORD_ADDRESS_I(addr[15:2]), .LOW_WORD_ADDRESS_I(addr[1:0]),
      .PROC_ADDR_STROBE_N_I(ps_n), .CTRL_ADDR_STROBE_N_I(cc_n), .BURST_ADVANCE_N_I(adv_n),
      .GLOBAL_WRITE_N_I(gw_n), .BYTE_WRITE_GATE_N_I(bwe_n), .BYTE_STROBE_N_I(bs_n),
      .CHIP_SELECTS_I(cs), .OUTPUT_ENABLE_N_I(oe_n), .SLEEP_REQUEST_I(sleep),
      .BURST_ORDER_SELECT_I(order), .FLOW_THROUGH_SELECT_I(flow),
      .DATA_LINES_I(dq_oe ? dq_out : req_data), .DATA_LINES_O(dq_out),
      .DATA_LINES_OE_O(dq_oe), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata));

   // -----------------------------------------------------------
   // Checking
   // -----------------------------------------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // A read shows two edges after its row was driven
   always @(posedge clk)
   begin
      st1 <= exp_v;
      d1 <= exp_x;
      st2 <= st1;
      d2 <= d1;
   end

   always @(posedge clk)
   begin
      #1;
      if (st2)
         check("read data", dq_out, d2);
      check("drive enable", {31'h0, dq_oe}, {31'h0, st2 & ~oe_n & ~sleep});
   end

   task results();
      $display("Comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   // -----------------------------------------------------------
   // Stimulus
   // -----------------------------------------------------------
   task run_rows(input int lo, input int hi);
      for (int i = lo; i <= hi; i++)
      begin
         i_sbs_requester.drive(ROWS[i].ctl, ROWS[i].bs, ROWS[i].a, ROWS[i].d);
         exp_v <= ROWS[i].chk & ~mute;
         exp_x <= ROWS[i].x;
      end
      // Deselect ends any burst, so strobes left standing cannot start more reads
      i_sbs_requester.drive(6'h27, 4'hF, 16'h0000, 32'h0);
      exp_v <= 1'h0;
      repeat (3) @(posedge clk);
   endtask : run_rows

   // Zero wait states are not assumed: each phase waits for ready
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sbs_pkg::HSIZE_WORD;
      do @(posedge clk); while (hready !== 1'h1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'h1);
      rd = hrdata;
      check("bus response", {31'h0, hresp}, {31'h0, sbs_pkg::HRESP_OKAY});
   endtask : ahb

   task do_reset(input logic ord);
      rst_n <= 1'h0;
      order <= ord;
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      repeat (8) @(posedge clk);
   endtask : do_reset

   initial
   begin
      // Run is about 140 cycles; the limit leaves a wide margin
      repeat (3000) @(posedge clk);
      err_total++;
      results();
   end

   initial
   begin
      {err_total, n_tests, exp_v, exp_x, st1, st2, d1, d2, mute} = '0;
      {rst_n, sleep, hold_oe, hsel, htrans, hwrite, haddr, hwdata} = '0;
      {order, flow, hsize} = {1'h1, 1'h1, sbs_pkg::HSIZE_WORD};
      repeat (5) @(posedge clk);
      check("reset read data", hrdata, 32'h0);
      do_reset(1'h1);
      run_rows(0, 18);
      // Output enable must act at once, not at the next edge
      run_rows(7, 7);
      hold_oe <= 1'h1;
      run_rows(7, 7);
      hold_oe <= 1'h0;
      run_rows(7, 7);
      sleep <= 1'h1;
      mute = 1'h1;
      run_rows(7, 7);
      sleep <= 1'h0;
      run_rows(8, 8);
      ahb(1'h0, 32'(sbs_pkg::CTRL_OFS), 32'h0);
      check("control reset", rd, 32'h0);
      ahb(1'h1, 32'(sbs_pkg::CTRL_OFS), 32'h1);
      run_rows(7, 7);
      ahb(1'h1, 32'(sbs_pkg::CTRL_OFS), 32'h0);
      mute = 1'h0;
      run_rows(7, 7);
      ahb(1'h1, 32'(sbs_pkg::STATUS_OFS), 32'hFFFFFFFF);
      ahb(1'h0, 32'(sbs_pkg::STATUS_OFS), 32'h0);
      check("straps", {30'h0, rd[2:1]}, 32'h3);
      // Burst ended, last op a read, low bits still as loaded at word 1
      check("status", {26'h0, rd[5:0]}, 32'h16);
      ahb(1'h0, 32'h00000008, 32'h0);
      check("unmapped read", rd, 32'h0);
      do_reset(1'h0);
      ahb(1'h0, 32'(sbs_pkg::STATUS_OFS), 32'h0);
      check("linear strap", {31'h0, rd[1]}, 32'h0);
      run_rows(0, 4);
      run_rows(19, 23);
      results();
   end
endmodule : testbench
`default_nettype wire
